// ### logic/alarm_event_irq.sv
// Purpose: Alarm and error event flags, enables and interrupt for one T1 receiver.
// Assumes: Detector inputs share clk; plain register port, read data one cycle later.
// Notes:   Status bits clear on read and on write-one; a new event beats the clear.

`timescale 1ns/1ps
`default_nettype none

module alarm_event_irq #(
    parameter int unsigned AIS_DECLARE = alarm_event_pkg::AIS_CYCLES,
    parameter int unsigned AIS_CLEAR   = alarm_event_pkg::AIS_CYCLES,
    parameter int unsigned YEL_DECLARE = alarm_event_pkg::YEL_CYCLES
) (
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic [alarm_event_pkg::ADDR_W-1:0]  addr,
    input  wire logic [alarm_event_pkg::DATA_W-1:0]  wr_data,
    input  wire logic                                wr_en,
    input  wire logic                                rd_en,
    output logic      [alarm_event_pkg::DATA_W-1:0]  rd_data,
    input  wire logic                                line_code_violation,
    input  wire logic                                frame_loss_state,
    input  wire logic                                alarm_indication_raw,
    input  wire logic                                remote_alarm_raw,
    output logic                                     alarm_indication_defect,
    output logic                                     remote_alarm_defect,
    output logic                                     irq
);
    import alarm_event_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  alarm_error_event_status;
    logic [DATA_W-1:0]  next_alarm_error_event_status;
    logic [DATA_W-1:0]  alarm_error_event_enable;
    logic [DATA_W-1:0]  next_alarm_error_event_enable;
    logic               alarm_block_irq_en;
    logic               next_alarm_block_irq_en;
    logic [DATA_W-1:0]  next_rd_data;
    logic               next_irq;
    logic               frame_loss_prev;
    logic               ais_prev;
    logic               yel_prev;
    logic               ais_state;
    logic               yel_state;
    logic [EVENT_N-1:0] event_set;
    logic [EVENT_N-1:0] event_clear;
    logic [EVENT_N-1:0] pending;

    logic line_code_violation_flag;
    logic frame_loss_change_flag;
    logic alarm_indication_change_flag;
    logic remote_alarm_change_flag;
    logic line_code_violation_irq_en;
    logic frame_loss_change_irq_en;
    logic alarm_indication_change_irq_en;
    logic remote_alarm_change_irq_en;

    logic status_hit;
    logic enable_hit;
    logic block_hit;
    logic state_hit;

    // ----------------------------------------------------------------
    // Defect qualification
    // ----------------------------------------------------------------
    defect_qualifier #(
        .DECLARE_CYCLES (AIS_DECLARE),
        .CLEAR_CYCLES   (AIS_CLEAR)
    ) u_ais_qual (
        .clk       (clk),
        .reset_n   (reset_n),
        .condition (alarm_indication_raw),
        .defect    (ais_state)
    );

    // Yellow clears on the first edge the condition is gone
    defect_qualifier #(
        .DECLARE_CYCLES (YEL_DECLARE),
        .CLEAR_CYCLES   (IMMEDIATE)
    ) u_yel_qual (
        .clk       (clk),
        .reset_n   (reset_n),
        .condition (remote_alarm_raw),
        .defect    (yel_state)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    always_comb begin
        status_hit = 1'b0;
        enable_hit = 1'b0;
        block_hit  = 1'b0;
        state_hit  = 1'b0;
        if (addr == STATUS_OFS) begin
            status_hit = 1'b1;
        end else if (addr == ENABLE_OFS) begin
            enable_hit = 1'b1;
        end else if (addr == BLOCK_OFS) begin
            block_hit = 1'b1;
        end else if (addr == STATE_OFS) begin
            state_hit = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    always_comb begin
        event_set          = '0;
        event_set[LCV_BIT] = line_code_violation;
        event_set[LOF_BIT] = frame_loss_state ^ frame_loss_prev;
        event_set[AIS_BIT] = ais_state ^ ais_prev;
        event_set[YEL_BIT] = yel_state ^ yel_prev;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_loss_prev <= 1'b0;
            ais_prev        <= 1'b0;
            yel_prev        <= 1'b0;
        end else begin
            frame_loss_prev <= frame_loss_state;
            ais_prev        <= ais_state;
            yel_prev        <= yel_state;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_comb begin
        event_clear = '0;
        // Read clears; write-one clears as well
        if (rd_en && status_hit) begin
            event_clear = EVENT_MASK;
        end else if (wr_en && status_hit) begin
            event_clear = wr_data[EVENT_N-1:0];
        end
        next_alarm_error_event_status = '0;
        // A set in the clearing cycle survives
        next_alarm_error_event_status[EVENT_N-1:0] =
            (alarm_error_event_status[EVENT_N-1:0] & ~event_clear) | event_set;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_error_event_status <= STATUS_RST;
        end else begin
            alarm_error_event_status <= next_alarm_error_event_status;
        end
    end

    assign line_code_violation_flag     = alarm_error_event_status[LCV_BIT];
    assign frame_loss_change_flag       = alarm_error_event_status[LOF_BIT];
    assign alarm_indication_change_flag = alarm_error_event_status[AIS_BIT];
    assign remote_alarm_change_flag     = alarm_error_event_status[YEL_BIT];

    // ----------------------------------------------------------------
    // Enable and block control
    // ----------------------------------------------------------------
    always_comb begin
        next_alarm_error_event_enable = alarm_error_event_enable;
        next_alarm_block_irq_en       = alarm_block_irq_en;
        if (wr_en && enable_hit) begin
            // All bits stored; bit 4 and up steer nothing here
            next_alarm_error_event_enable = wr_data;
        end
        if (wr_en && block_hit) begin
            next_alarm_block_irq_en = wr_data[BLOCK_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_error_event_enable <= ENABLE_RST;
            alarm_block_irq_en       <= BLOCK_EN_RST;
        end else begin
            alarm_error_event_enable <= next_alarm_error_event_enable;
            alarm_block_irq_en       <= next_alarm_block_irq_en;
        end
    end

    assign line_code_violation_irq_en     = alarm_error_event_enable[LCV_BIT];
    assign frame_loss_change_irq_en       = alarm_error_event_enable[LOF_BIT];
    assign alarm_indication_change_irq_en = alarm_error_event_enable[AIS_BIT];
    assign remote_alarm_change_irq_en     = alarm_error_event_enable[YEL_BIT];

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    always_comb begin
        pending          = '0;
        pending[LCV_BIT] = line_code_violation_flag & line_code_violation_irq_en;
        pending[LOF_BIT] = frame_loss_change_flag & frame_loss_change_irq_en;
        pending[AIS_BIT] = alarm_indication_change_flag & alarm_indication_change_irq_en;
        pending[YEL_BIT] = remote_alarm_change_flag & remote_alarm_change_irq_en;
        // Registered output lags the flags by one edge
        next_irq = alarm_block_irq_en & (|pending);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // Read data and defect outputs
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = '0;
        if (rd_en) begin
            if (status_hit) begin
                next_rd_data = alarm_error_event_status;
            end else if (enable_hit) begin
                next_rd_data = alarm_error_event_enable;
            end else if (block_hit) begin
                next_rd_data[BLOCK_EN_BIT] = alarm_block_irq_en;
            end else if (state_hit) begin
                next_rd_data[LOF_BIT] = frame_loss_state;
                next_rd_data[AIS_BIT] = ais_state;
                next_rd_data[YEL_BIT] = yel_state;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data                 <= '0;
            alarm_indication_defect <= 1'b0;
            remote_alarm_defect     <= 1'b0;
        end else begin
            rd_data                 <= next_rd_data;
            alarm_indication_defect <= ais_state;
            remote_alarm_defect     <= yel_state;
        end
    end

endmodule : alarm_event_irq

`default_nettype wire

// ### logic/alarm_event_pkg.sv
// Purpose: Shared constants for the T1 alarm and error interrupt block.
// Assumes: 100 MHz clock, byte-wide register port.
// Notes:   Offsets, fields, reset values and timing counts live here only.

package alarm_event_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 32;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h01;
    localparam logic [ADDR_W-1:0] BLOCK_OFS  = 8'h02;
    localparam logic [ADDR_W-1:0] STATE_OFS  = 8'h03;

    // ----------------------------------------------------------------
    // Field positions (status and enable share one layout)
    // ----------------------------------------------------------------
    localparam int unsigned YEL_BIT      = 0;
    localparam int unsigned AIS_BIT      = 1;
    localparam int unsigned LOF_BIT      = 2;
    localparam int unsigned LCV_BIT      = 3;
    localparam int unsigned EVENT_N      = 4;
    localparam int unsigned BLOCK_EN_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0]  STATUS_RST   = 8'h00;
    localparam logic [DATA_W-1:0]  ENABLE_RST   = 8'h00;
    localparam logic               BLOCK_EN_RST = 1'b0;
    localparam logic [EVENT_N-1:0] EVENT_MASK   = 4'hf;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned CYCLES_PER_MS  = CLK_HZ / 1000;
    localparam int unsigned AIS_PERSIST_MS = 42;
    localparam int unsigned YEL_PERSIST_MS = 900;
    localparam int unsigned AIS_CYCLES     = AIS_PERSIST_MS * CYCLES_PER_MS;
    localparam int unsigned YEL_CYCLES     = YEL_PERSIST_MS * CYCLES_PER_MS;
    localparam int unsigned IMMEDIATE      = 1;

endpackage : alarm_event_pkg

// ### logic/defect_qualifier.sv
// Purpose: Declares or clears a defect once its raw condition persists.
// Assumes: Raw condition from logic on the same clock.
// Notes:   A count of one means the state follows the condition next edge.

`timescale 1ns/1ps
`default_nettype none

module defect_qualifier #(
    parameter int unsigned DECLARE_CYCLES = 1,
    parameter int unsigned CLEAR_CYCLES   = 1
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic condition,
    output logic      defect
);
    import alarm_event_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_defect;
    logic [CNT_W-1:0] limit;

    // ----------------------------------------------------------------
    // Persistence counter
    // ----------------------------------------------------------------
    always_comb begin
        limit       = defect ? CNT_W'(CLEAR_CYCLES - 1) : CNT_W'(DECLARE_CYCLES - 1);
        next_count  = '0;
        next_defect = defect;
        // Any return to agreement restarts the wait
        if (condition != defect) begin
            if (count >= limit) begin
                next_defect = condition;
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count  <= '0;
            defect <= 1'b0;
        end else begin
            count  <= next_count;
            defect <= next_defect;
        end
    end

endmodule : defect_qualifier

`default_nettype wire

// ### sim/alarm_event_irq_asserts.sv
// Purpose: Port-level checks for the alarm event interrupt block.
// Assumes: One clock; enables are shadowed from register writes.
// Notes:   Persistence bounds are lower limits only; the yellow clear window allows slack.
`timescale 1ns/1ps
`default_nettype none
module alarm_event_irq_asserts #(
    parameter int unsigned AIS_DECLARE = 8,
    parameter int unsigned YEL_DECLARE = 20
) (
    input wire logic                               clk,
    input wire logic                               reset_n,
    input wire logic [alarm_event_pkg::ADDR_W-1:0] addr,
    input wire logic [alarm_event_pkg::DATA_W-1:0] wr_data,
    input wire logic                               wr_en,
    input wire logic                               rd_en,
    input wire logic [alarm_event_pkg::DATA_W-1:0] rd_data,
    input wire logic                               line_code_violation,
    input wire logic                               frame_loss_state,
    input wire logic                               alarm_indication_raw,
    input wire logic                               remote_alarm_raw,
    input wire logic                               alarm_indication_defect,
    input wire logic                               remote_alarm_defect,
    input wire logic                               irq
);
    import alarm_event_pkg::*;
    // ----
    // Shadow state
    // ----
    logic [DATA_W-1:0] en, next_en;
    logic              blk, next_blk;
    int unsigned       ais_run, next_ais_run, yel_run, next_yel_run;
    logic              stat_rd;
    assign stat_rd = rd_en && addr == STATUS_OFS;
    always_comb begin
        next_en = en;
        next_blk = blk;
        next_ais_run = alarm_indication_raw ? ais_run + 1 : 0;
        next_yel_run = remote_alarm_raw ? yel_run + 1 : 0;
        if (wr_en && addr == ENABLE_OFS)
            next_en = wr_data;
        if (wr_en && addr == BLOCK_OFS)
            next_blk = wr_data[BLOCK_EN_BIT];
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en <= ENABLE_RST;
            blk <= BLOCK_EN_RST;
            ais_run <= 0;
            yel_run <= 0;
        end else begin
            en <= next_en;
            blk <= next_blk;
            ais_run <= next_ais_run;
            yel_run <= next_yel_run;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // A read or write-one in the middle cycle may clear the flag lawfully
    lcv_flag_a: assert property (
        line_code_violation ##1 !stat_rd && !(wr_en && addr == STATUS_OFS)
        ##1 stat_rd |=> rd_data[LCV_BIT])
        else $error("line code flag missing");
    lof_flag_a: assert property (
        $changed(frame_loss_state) && en[LOF_BIT] && blk && !wr_en |-> ##2 irq)
        else $error("frame loss change flag missing");
    // Flag and defect output both move one edge after the internal state
    ais_flag_a: assert property (
        $changed(alarm_indication_defect) && en[AIS_BIT] && blk |=> irq)
        else $error("alarm indication change flag missing");
    yel_flag_a: assert property (
        $changed(remote_alarm_defect) && en[YEL_BIT] && blk |=> irq)
        else $error("remote alarm change flag missing");
    read_clear_a: assert property (
        stat_rd && !line_code_violation ##1 !line_code_violation ##1 stat_rd
        |=> !rd_data[LCV_BIT])
        else $error("status not cleared by read");
    lcv_irq_a: assert property (
        line_code_violation && en[LCV_BIT] && blk && !wr_en |-> ##2 irq)
        else $error("enabled violation gave no interrupt");
    block_gate_a: assert property (
        !blk |=> !irq)
        else $error("interrupt with block enable clear");
    no_source_a: assert property (
        en[EVENT_N-1:0] == '0 |=> !irq)
        else $error("interrupt with no source enabled");
    ais_hold_a: assert property (
        $rose(alarm_indication_defect) |-> $past(ais_run, 2) + 1 >= AIS_DECLARE)
        else $error("alarm indication declared too early");
    yel_hold_a: assert property (
        $rose(remote_alarm_defect) |-> $past(yel_run, 2) + 1 >= YEL_DECLARE)
        else $error("remote alarm declared too early");
    yel_drop_a: assert property (
        $fell(remote_alarm_raw) |-> ##[1:4] !remote_alarm_defect)
        else $error("remote alarm not cleared promptly");
endmodule : alarm_event_irq_asserts
bind alarm_event_irq alarm_event_irq_asserts #(
    .AIS_DECLARE(AIS_DECLARE), .YEL_DECLARE(YEL_DECLARE)) chk_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .line_code_violation(line_code_violation), .frame_loss_state(frame_loss_state),
    .alarm_indication_raw(alarm_indication_raw), .remote_alarm_raw(remote_alarm_raw),
    .alarm_indication_defect(alarm_indication_defect),
    .remote_alarm_defect(remote_alarm_defect), .irq(irq));
`default_nettype wire

// ### sim/t1_line_model.sv
// Purpose: Receive line and framer detector stand-in.
// Assumes: Detector levels and pulses share the block clock.
// Notes:   Selector 0 yellow, 1 alarm indication, 2 frame loss, else violation.
`timescale 1ns/1ps
`default_nettype none
module t1_line_model (
    input  wire logic clk,
    output logic      line_code_violation,
    output logic      frame_loss_state,
    output logic      alarm_indication_raw,
    output logic      remote_alarm_raw
);
    // ----
    // Line events
    // ----
    initial begin
        line_code_violation = 1'b0;
        frame_loss_state = 1'b0;
        alarm_indication_raw = 1'b0;
        remote_alarm_raw = 1'b0;
    end
    // Violation is a one-cycle pulse; levels hold until driven again
    task automatic drive(input int sel, input logic v);
        @(posedge clk);
        case (sel)
            0: remote_alarm_raw <= v;
            1: alarm_indication_raw <= v;
            2: frame_loss_state <= v;
            default: line_code_violation <= 1'b1;
        endcase
        @(posedge clk);
        line_code_violation <= 1'b0;
    endtask : drive
endmodule : t1_line_model
`default_nettype wire

// ### sim/test_t1_alarm_error_interrupts.sv
// Purpose: Self-checking bench for the alarm event interrupt block.
// Assumes: Short qualifier counts; line model drives the detector inputs.
// Notes:   Waits are sized from qualifier counts plus pipeline slack.
`timescale 1ns/1ps
`default_nettype none
module test_t1_alarm_error_interrupts;
    import alarm_event_pkg::*;
    // ----
    // Bench
    // ----
    localparam int unsigned AIS_N = 8;
    localparam int unsigned YEL_N = 20;
    localparam int unsigned HOLD  = YEL_N + 6;
    logic              clk     = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] addr    = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic              wr_en   = 1'b0;
    logic              rd_en   = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic              lcv, lof, ais_raw, yel_raw, ais_def, yel_def, irq;
    int                failures   = 0;
    int                num_checks = 0;
    int                cycles     = 0;
    always #5 clk = ~clk;
    alarm_event_irq #(.AIS_DECLARE(AIS_N), .AIS_CLEAR(AIS_N), .YEL_DECLARE(YEL_N)) dut_u (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .line_code_violation(lcv),
        .frame_loss_state(lof), .alarm_indication_raw(ais_raw), .remote_alarm_raw(yel_raw),
        .alarm_indication_defect(ais_def), .remote_alarm_defect(yel_def), .irq(irq));
    t1_line_model line_u (.clk(clk), .line_code_violation(lcv), .frame_loss_state(lof),
        .alarm_indication_raw(ais_raw), .remote_alarm_raw(yel_raw));
    task automatic cmp_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask : cmp_bit
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        cmp_byte(rd_data, exp);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic complete_run;
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(STATUS_OFS, 8'h00);
        rd(ENABLE_OFS, 8'h00);
        rd(8'h7f, 8'h00);
        wr(ENABLE_OFS, 8'he0);
        wr(BLOCK_OFS, 8'h01);
        rd(ENABLE_OFS, 8'he0);
        line_u.drive(3, 1'b1);
        line_u.drive(3, 1'b1);
        rd(STATUS_OFS, 8'h08);
        cmp_bit(irq, 1'b0);
        rd(STATUS_OFS, 8'h00);
        // Write-one clears only the bits it names
        line_u.drive(3, 1'b1);
        wr(STATUS_OFS, 8'h07);
        rd(STATUS_OFS, 8'h08);
        wr(STATUS_OFS, 8'h08);
        rd(STATUS_OFS, 8'h00);
        wr(BLOCK_OFS, 8'h00);
        wr(ENABLE_OFS, 8'h08);
        line_u.drive(3, 1'b1);
        settle(3);
        cmp_bit(irq, 1'b0);
        wr(BLOCK_OFS, 8'h01);
        settle(2);
        cmp_bit(irq, 1'b1);
        rd(STATUS_OFS, 8'h08);
        settle(2);
        cmp_bit(irq, 1'b0);
        // Alarm indication shorter than its hold must leave no trace
        line_u.drive(1, 1'b1);
        settle(AIS_N - 3);
        line_u.drive(1, 1'b0);
        settle(AIS_N + 4);
        cmp_bit(ais_def, 1'b0);
        rd(STATUS_OFS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ENABLE_OFS, 8'(8'h01 << i));
            rd(ENABLE_OFS, 8'(8'h01 << i));
            for (int v = 1; v >= 0; v--) begin
                line_u.drive(i, v[0]);
                settle(HOLD);
                cmp_bit(irq, 1'b1);
                if (i < 2)
                    cmp_bit(i == 1 ? ais_def : yel_def, v[0]);
                rd(STATE_OFS, i < 3 ? (8'(v) << i) : 8'h00);
                rd(STATUS_OFS, 8'(8'h01 << i));
            end
        end
        settle(2);
        cmp_bit(irq, 1'b0);
        complete_run();
    end
endmodule : test_t1_alarm_error_interrupts
`default_nettype wire
